// ==== rtl/flash_host_pkg.sv ====
// Constants, types and layouts shared by the flash status host controller.
// Overview of operation
// - Host reads erase_timer_bit before and after each added sector erase.
// - After buffer abort, host issues the write-buffer-abort-reset sequence.
// - Host polls status at a valid programmed or erasing address; the code polls the last written word address, also during an erase.
// - Buffered program is polled at the last loaded word address.
// - Host leaves error status by writing reset or status-register-clear.
package flash_host_pkg;

   // Flash bus widths.
   localparam int ADDR_W = 22;
   localparam int DATA_W = 16;

   // Bus timing, in nanoseconds, and the derived cycle counts.
   localparam int CLK_NS   = 10;
   localparam int T_ACC_NS = 70;
   localparam int T_WP_NS  = 35;
   localparam int T_REC_NS = 20;
   localparam int ACC_CYC  = (T_ACC_NS + CLK_NS - 1) / CLK_NS;
   localparam int WP_CYC   = (T_WP_NS + CLK_NS - 1) / CLK_NS;
   localparam int REC_CYC  = (T_REC_NS + CLK_NS - 1) / CLK_NS;
   localparam int SYNC_CYC = 2;

   // Register byte offsets on the Wishbone side.
   localparam logic [7:0] REG_CMD    = 8'h00;
   localparam logic [7:0] REG_ADDR   = 8'h04;
   localparam logic [7:0] REG_WDATA  = 8'h08;
   localparam logic [7:0] REG_STATUS = 8'h0C;
   localparam logic [7:0] REG_RDATA  = 8'h10;

   // Status register bit positions.
   localparam int ST_BUSY     = 0;
   localparam int ST_DONE     = 1;
   localparam int ST_TIMEOUT  = 2;
   localparam int ST_ABORT    = 3;
   localparam int ST_NOT_ACC  = 4;
   localparam int ST_READY    = 5;
   localparam int ST_REFUSED  = 6;
   localparam int ST_W        = 7;

   // Status bit positions on the flash data bus.
   localparam int BIT_DATA_POLL   = 7;
   localparam int BIT_TOGGLE_ONE  = 6;
   localparam int BIT_TIMING      = 5;
   localparam int BIT_ERASE_TIMER = 3;
   localparam int BIT_TOGGLE_TWO  = 2;
   localparam int BIT_BUF_ABORT   = 1;

   // Command addresses and data written to the flash.
   localparam logic [ADDR_W-1:0] UNLOCK1_ADDR  = 22'h00_0555;
   localparam logic [ADDR_W-1:0] UNLOCK2_ADDR  = 22'h00_02AA;
   localparam logic [DATA_W-1:0] CMD_UNLOCK1   = 16'h00AA;
   localparam logic [DATA_W-1:0] CMD_UNLOCK2   = 16'h0055;
   localparam logic [DATA_W-1:0] CMD_RESET     = 16'h00F0;
   localparam logic [DATA_W-1:0] CMD_SR_CLEAR  = 16'h0071;
   localparam logic [DATA_W-1:0] CMD_SEC_ERASE = 16'h0030;

   // Values after reset.
   localparam logic [ADDR_W-1:0] ADDR_RST = 22'h00_0000;
   localparam logic [DATA_W-1:0] DATA_RST = 16'h0000;

   // Operations that software starts through the command register.
   typedef enum logic [2:0] {
      OP_WRITE       = 3'h0,
      OP_READ        = 3'h1,
      OP_POLL        = 3'h2,
      OP_ERASE_ADD   = 3'h3,
      OP_CLR_RESET   = 3'h4,
      OP_CLR_SR      = 3'h5,
      OP_ABORT_RESET = 3'h6
   } op_e;

   // One flash bus cycle request.
   typedef struct packed {
      logic              we;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] data;
   } cyc_req_s;

endpackage

// ==== rtl/flash_bus_cycle.sv ====
// Single asynchronous flash bus read or write cycle engine.
`timescale 1ns/1ps
module flash_bus_cycle (
   input  wire logic                                clk_i,
   input  wire logic                                rst_i,
   input  wire logic                                start_i,
   input  wire flash_host_pkg::cyc_req_s            req_i,
   input  wire logic [flash_host_pkg::DATA_W-1:0]   dq_i,
   output logic                                     done_o,
   output logic [flash_host_pkg::DATA_W-1:0]        rdata_o,
   output logic [flash_host_pkg::ADDR_W-1:0]        flash_addr_o,
   output logic [flash_host_pkg::DATA_W-1:0]        dq_o,
   output logic                                     dq_oe_o,
   output logic                                     ce_n_o,
   output logic                                     oe_n_o,
   output logic                                     we_n_o
);

   typedef enum logic [1:0] {
      C_IDLE = 2'b00,
      C_ACT  = 2'b01,
      C_REC  = 2'b11
   } cyc_e;

   cyc_e                              state_q;
   logic [7:0]                        cnt_q;
   logic                              we_q;
   logic [flash_host_pkg::DATA_W-1:0] dq_s1_q;
   logic [flash_host_pkg::DATA_W-1:0] dq_s2_q;

   // The data pins change outside our clock, so they pass two flops first.
   always_ff @(posedge clk_i) begin
      dq_s1_q <= dq_i;
      dq_s2_q <= dq_s1_q;
   end

   // Cycle sequencer; a read holds output enable for the access time plus the
   // synchroniser delay, so the sample taken at the end is settled data.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state_q      <= C_IDLE;
         cnt_q        <= 8'h00;
         we_q         <= 1'b0;
         done_o       <= 1'b0;
         rdata_o      <= flash_host_pkg::DATA_RST;
         flash_addr_o <= flash_host_pkg::ADDR_RST;
         dq_o         <= flash_host_pkg::DATA_RST;
         dq_oe_o      <= 1'b0;
         ce_n_o       <= 1'b1;
         oe_n_o       <= 1'b1;
         we_n_o       <= 1'b1;
      end else begin
         done_o <= 1'b0;
         case (state_q)
            C_IDLE: begin
               if (start_i) begin
                  flash_addr_o <= req_i.addr;
                  dq_o         <= req_i.data;
                  we_q         <= req_i.we;
                  ce_n_o       <= 1'b0;
                  state_q      <= C_ACT;
                  if (req_i.we) begin
                     we_n_o  <= 1'b0;
                     dq_oe_o <= 1'b1;
                     cnt_q   <= 8'(flash_host_pkg::WP_CYC - 1);
                  end else begin
                     oe_n_o <= 1'b0;
                     cnt_q  <= 8'(flash_host_pkg::ACC_CYC + flash_host_pkg::SYNC_CYC - 1);
                  end
               end
            end
            C_ACT: begin
               if (cnt_q == 8'h00) begin
                  ce_n_o  <= 1'b1;
                  oe_n_o  <= 1'b1;
                  we_n_o  <= 1'b1;
                  cnt_q   <= 8'(flash_host_pkg::REC_CYC - 1);
                  state_q <= C_REC;
                  if (!we_q) begin
                     rdata_o <= dq_s2_q;
                  end
               end else begin
                  cnt_q <= cnt_q - 8'h01;
               end
            end
            C_REC: begin
               // Address and data stay put here to give hold time after the
               // write enable rises.
               if (cnt_q == 8'h00) begin
                  dq_oe_o <= 1'b0;
                  done_o  <= 1'b1;
                  state_q <= C_IDLE;
               end else begin
                  cnt_q <= cnt_q - 8'h01;
               end
            end
            default: begin
               state_q <= C_IDLE;
            end
         endcase
      end
   end

endmodule

// ==== rtl/flash_host_ctrl.sv ====
// Wishbone-controlled host that drives a parallel flash and evaluates its status.
//
// The Wishbone register port and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
module flash_host_ctrl (
   input  wire logic                                clk_i,
   input  wire logic                                rst_i,
   input  wire logic                                wb_cyc_i,
   input  wire logic                                wb_stb_i,
   input  wire logic                                wb_we_i,
   input  wire logic [7:0]                          wb_adr_i,
   input  wire logic [3:0]                          wb_sel_i,
   input  wire logic [31:0]                         wb_dat_i,
   output logic                                     wb_ack_o,
   output logic [31:0]                              wb_dat_o,
   input  wire logic [flash_host_pkg::DATA_W-1:0]   dq_i,
   output logic [flash_host_pkg::DATA_W-1:0]        dq_o,
   output logic                                     dq_oe_o,
   output logic [flash_host_pkg::ADDR_W-1:0]        flash_addr_o,
   output logic                                     ce_n_o,
   output logic                                     oe_n_o,
   output logic                                     we_n_o,
   input  wire logic                                ready_busy_n_i
);

   typedef enum logic [1:0] {
      S_IDLE  = 2'b00,
      S_ISSUE = 2'b01,
      S_WAIT  = 2'b11,
      S_NEXT  = 2'b10
   } seq_e;

   seq_e                              state_q;
   flash_host_pkg::op_e               op_q;
   logic [1:0]                        step_q;
   logic [flash_host_pkg::ADDR_W-1:0] addr_q;
   logic [flash_host_pkg::DATA_W-1:0] wdata_q;
   logic [flash_host_pkg::ADDR_W-1:0] poll_addr_q;
   logic [flash_host_pkg::DATA_W-1:0] rdata_q;
   logic [flash_host_pkg::DATA_W-1:0] first_q;
   flash_host_pkg::cyc_req_s          req_q;
   logic                              start_q;
   logic                              eng_done;
   logic [flash_host_pkg::DATA_W-1:0] eng_rdata;
   logic [flash_host_pkg::ST_W-1:0]   flag_q;
   logic [flash_host_pkg::ST_W-1:0]   flag_set;
   logic                              rb_s1_q;
   logic                              rb_s2_q;
   logic                              ack_q;
   logic                              bus_wr;
   logic                              cmd_wr;
   logic                              fin;
   logic                              poll_same;

   // Byte-lane mask for a 32-bit write.
   function automatic logic [31:0] lane_mask(input logic [3:0] sel);
      logic [31:0] m;
      m = 32'h0000_0000;
      for (int i = 0; i < 4; i++) begin
         m[i*8 +: 8] = {8{sel[i]}};
      end
      return m;
   endfunction

   // The flash cycle each operation issues at each step.
   function automatic flash_host_pkg::cyc_req_s step_req(
      input flash_host_pkg::op_e               op,
      input logic [1:0]                        step,
      input logic [flash_host_pkg::ADDR_W-1:0] addr,
      input logic [flash_host_pkg::DATA_W-1:0] wdata,
      input logic [flash_host_pkg::ADDR_W-1:0] paddr);
      flash_host_pkg::cyc_req_s r;
      r = '{we: 1'b0, addr: addr, data: flash_host_pkg::DATA_RST};
      case (op)
         flash_host_pkg::OP_WRITE:     r = '{we: 1'b1, addr: addr, data: wdata};
         flash_host_pkg::OP_POLL:      r.addr = paddr;
         flash_host_pkg::OP_ERASE_ADD: begin
            if (step == 2'd1) begin
               r = '{we: 1'b1, addr: addr, data: flash_host_pkg::CMD_SEC_ERASE};
            end
         end
         flash_host_pkg::OP_CLR_RESET: begin
            r = '{we: 1'b1, addr: addr, data: flash_host_pkg::CMD_RESET};
         end
         flash_host_pkg::OP_CLR_SR: begin
            r = '{we: 1'b1, addr: flash_host_pkg::UNLOCK1_ADDR,
                  data: flash_host_pkg::CMD_SR_CLEAR};
         end
         flash_host_pkg::OP_ABORT_RESET: begin
            case (step)
               2'd0: r = '{we: 1'b1, addr: flash_host_pkg::UNLOCK1_ADDR,
                           data: flash_host_pkg::CMD_UNLOCK1};
               2'd1: r = '{we: 1'b1, addr: flash_host_pkg::UNLOCK2_ADDR,
                           data: flash_host_pkg::CMD_UNLOCK2};
               default: r = '{we: 1'b1, addr: flash_host_pkg::UNLOCK1_ADDR,
                              data: flash_host_pkg::CMD_RESET};
            endcase
         end
         default: r.we = 1'b0;
      endcase
      return r;
   endfunction

   assign bus_wr    = wb_cyc_i && wb_stb_i && wb_we_i && !ack_q;
   assign cmd_wr    = bus_wr && wb_sel_i[0] && (wb_adr_i == flash_host_pkg::REG_CMD);
   assign poll_same = eng_rdata[flash_host_pkg::BIT_TOGGLE_ONE] ==
                      first_q[flash_host_pkg::BIT_TOGGLE_ONE];

   // The ready/busy line comes from another chip, so it is synchronised.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         rb_s1_q <= 1'b1;
         rb_s2_q <= 1'b1;
      end else begin
         rb_s1_q <= ready_busy_n_i;
         rb_s2_q <= rb_s1_q;
      end
   end

   // Event decode: refused flag on a command write while busy or with code 7; finish and other sticky flags at the end of each flash cycle.
   always_comb begin
      fin      = 1'b0;
      flag_set = '0;
      if (cmd_wr && (state_q != S_IDLE || wb_dat_i[2:0] == 3'h7)) begin
         flag_set[flash_host_pkg::ST_REFUSED] = 1'b1;
      end
      if (state_q == S_NEXT) begin
         case (op_q)
            flash_host_pkg::OP_POLL: begin
               if (step_q == 2'd0) begin
                  fin = 1'b0;
               end else if (poll_same) begin
                  fin = 1'b1;
               end else if (step_q == 2'd2) begin
                  fin = 1'b1;
                  flag_set[flash_host_pkg::ST_TIMEOUT] = 1'b1;
               end else if (eng_rdata[flash_host_pkg::BIT_BUF_ABORT]) begin
                  fin = 1'b1;
                  flag_set[flash_host_pkg::ST_ABORT] = 1'b1;
               end
            end
            flash_host_pkg::OP_ERASE_ADD: begin
               // Erase timer high before or after the added command means
               // the sector may not have joined the erase.
               if (step_q != 2'd1 && eng_rdata[flash_host_pkg::BIT_ERASE_TIMER]) begin
                  fin = 1'b1;
                  flag_set[flash_host_pkg::ST_NOT_ACC] = 1'b1;
               end else if (step_q == 2'd2) begin
                  fin = 1'b1;
               end
            end
            flash_host_pkg::OP_ABORT_RESET: fin = (step_q == 2'd2);
            default: fin = 1'b1;
         endcase
         flag_set[flash_host_pkg::ST_DONE] = fin;
      end
   end

   // Operation sequencer. A poll that still toggles with the timing bit high
   // gets exactly one more read: the toggle may just have stopped.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state_q <= S_IDLE;
         op_q    <= flash_host_pkg::OP_READ;
         step_q  <= 2'd0;
         start_q <= 1'b0;
         req_q   <= '0;
         first_q <= flash_host_pkg::DATA_RST;
      end else begin
         start_q <= (state_q == S_ISSUE);
         case (state_q)
            S_IDLE: begin
               if (cmd_wr && wb_dat_i[2:0] != 3'h7) begin
                  op_q    <= flash_host_pkg::op_e'(wb_dat_i[2:0]);
                  step_q  <= 2'd0;
                  state_q <= S_ISSUE;
               end
            end
            S_ISSUE: begin
               req_q   <= step_req(op_q, step_q, addr_q, wdata_q, poll_addr_q);
               state_q <= S_WAIT;
            end
            S_WAIT: begin
               if (eng_done) begin
                  state_q <= S_NEXT;
               end
            end
            S_NEXT: begin
               first_q <= eng_rdata;
               if (fin) begin
                  state_q <= S_IDLE;
               end else begin
                  state_q <= S_ISSUE;
                  if (op_q == flash_host_pkg::OP_POLL) begin
                     if (step_q == 2'd0 || eng_rdata[flash_host_pkg::BIT_TIMING]) begin
                        step_q <= step_q + 2'd1;
                     end
                  end else begin
                     step_q <= step_q + 2'd1;
                  end
               end
            end
            default: state_q <= S_IDLE;
         endcase
      end
   end

   // Software-visible data registers; a plain word write sets the poll address.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         addr_q      <= flash_host_pkg::ADDR_RST;
         wdata_q     <= flash_host_pkg::DATA_RST;
         poll_addr_q <= flash_host_pkg::ADDR_RST;
         rdata_q     <= flash_host_pkg::DATA_RST;
      end else begin
         if (bus_wr && wb_adr_i == flash_host_pkg::REG_ADDR && state_q == S_IDLE) begin
            addr_q <= flash_host_pkg::ADDR_W'((32'(addr_q) & ~lane_mask(wb_sel_i)) |
                                              (wb_dat_i & lane_mask(wb_sel_i)));
         end
         if (bus_wr && wb_adr_i == flash_host_pkg::REG_WDATA && state_q == S_IDLE) begin
            wdata_q <= flash_host_pkg::DATA_W'((32'(wdata_q) & ~lane_mask(wb_sel_i)) |
                                               (wb_dat_i & lane_mask(wb_sel_i)));
         end
         if (state_q == S_NEXT && op_q == flash_host_pkg::OP_WRITE) begin
            poll_addr_q <= addr_q;
         end
         if (state_q == S_NEXT && op_q != flash_host_pkg::OP_WRITE && !req_q.we) begin
            rdata_q <= eng_rdata;
         end
      end
   end

   // Sticky flags, cleared by writing ones; a set in the same cycle wins.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         flag_q <= '0;
      end else if (bus_wr && wb_sel_i[0] && wb_adr_i == flash_host_pkg::REG_STATUS) begin
         flag_q <= (flag_q & ~wb_dat_i[flash_host_pkg::ST_W-1:0]) | flag_set;
      end else begin
         flag_q <= flag_q | flag_set;
      end
   end

   // Classic Wishbone slave: ack one cycle after the strobe, unmapped reads zero.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_q    <= 1'b0;
         wb_dat_o <= 32'h0000_0000;
      end else begin
         ack_q <= wb_cyc_i && wb_stb_i && !ack_q;
         case (wb_adr_i)
            flash_host_pkg::REG_CMD:    wb_dat_o <= {29'h0000_0000, op_q};
            flash_host_pkg::REG_ADDR:   wb_dat_o <= 32'(addr_q);
            flash_host_pkg::REG_WDATA:  wb_dat_o <= 32'(wdata_q);
            flash_host_pkg::REG_STATUS: begin
               wb_dat_o <= 32'(flag_q);
               wb_dat_o[flash_host_pkg::ST_BUSY]  <= (state_q != S_IDLE);
               wb_dat_o[flash_host_pkg::ST_READY] <= rb_s2_q;
            end
            flash_host_pkg::REG_RDATA:  wb_dat_o <= 32'(rdata_q);
            default:                    wb_dat_o <= 32'h0000_0000;
         endcase
      end
   end

   assign wb_ack_o = ack_q;

   flash_bus_cycle u_cycle (
      .clk_i        (clk_i),
      .rst_i        (rst_i),
      .start_i      (start_q),
      .req_i        (req_q),
      .dq_i         (dq_i),
      .done_o       (eng_done),
      .rdata_o      (eng_rdata),
      .flash_addr_o (flash_addr_o),
      .dq_o         (dq_o),
      .dq_oe_o      (dq_oe_o),
      .ce_n_o       (ce_n_o),
      .oe_n_o       (oe_n_o),
      .we_n_o       (we_n_o)
   );

   // Polling reads go out on the tracked poll address.
   poll_address_a: assert property (@(posedge clk_i) disable iff (rst_i)
      (start_q && op_q == flash_host_pkg::OP_POLL) |=> (flash_addr_o == poll_addr_q))
      else $error("poll read not at poll address");

   // The last written word address becomes the poll address.
   poll_track_a: assert property (@(posedge clk_i) disable iff (rst_i)
      (state_q == S_NEXT && op_q == flash_host_pkg::OP_WRITE) |=>
         (poll_addr_q == $past(addr_q)))
      else $error("poll address not tracking last write");

   // An accepted sector erase write is followed by a status re-read.
   erase_recheck_a: assert property (@(posedge clk_i) disable iff (rst_i)
      (start_q && op_q == flash_host_pkg::OP_ERASE_ADD && req_q.we) |->
         ##[1:40] (start_q && !req_q.we && step_q == 2'd2))
      else $error("no erase timer re-check after erase command");

   // Abort reset opens with the unlock pair.
   abort_sequence_a: assert property (@(posedge clk_i) disable iff (rst_i)
      (start_q && op_q == flash_host_pkg::OP_ABORT_RESET && step_q == 2'd0) |->
         (req_q.data == flash_host_pkg::CMD_UNLOCK1) ##[1:40]
         (start_q && req_q.data == flash_host_pkg::CMD_UNLOCK2 &&
          req_q.addr == flash_host_pkg::UNLOCK2_ADDR))
      else $error("abort reset sequence malformed");

   // Error clearing writes the reset or status-clear command.
   clear_command_a: assert property (@(posedge clk_i) disable iff (rst_i)
      (start_q && (op_q == flash_host_pkg::OP_CLR_RESET ||
                   op_q == flash_host_pkg::OP_CLR_SR)) |->
         (req_q.we && req_q.data == ((op_q == flash_host_pkg::OP_CLR_RESET) ?
                                      flash_host_pkg::CMD_RESET :
                                      flash_host_pkg::CMD_SR_CLEAR)))
      else $error("error clear command data wrong");

endmodule

// ==== tb/flash_dev_model.sv ====
// Behavioural flash device that answers host bus cycles with status words.
`timescale 1ns/1ps
module flash_dev_model (
   input  wire logic        clk_i,
   input  wire logic        load_i,
   input  wire logic [2:0]  mode_i,
   input  wire logic        ce_n_i,
   input  wire logic        oe_n_i,
   input  wire logic        we_n_i,
   input  wire logic [21:0] addr_i,
   input  wire logic [15:0] dq_i,
   input  wire logic        dq_oe_i,
   output logic [15:0]      bus_o,
   output logic             ready_busy_n_o
);
   logic [2:0]  mode_q = 3'h0;
   logic [15:0] mem_q = 16'h0000;
   logic [15:0] last_q = 16'h0000;
   logic        tog_q = 1'b0;
   logic        we_q = 1'b1;
   logic        oe_q = 1'b1;
   logic        sr_q = 1'b0;
   logic [7:0]  st;
   // Mode 1 programs, 2 aborts a buffer, 3 failed erase, 4 erase window, 5 erasing,
   // 6 erase suspended.
   assign st = {mode_q < 3'h3 || mode_q == 3'h6, tog_q, mode_q == 3'h3, 1'b0,
                mode_q == 3'h3 || mode_q == 3'h5, tog_q & (mode_q > 3'h2), mode_q == 3'h2,
                1'b0};
   // Nothing holds released data lines, so they show the inverse of the last driven value.
   assign bus_o = dq_oe_i ? dq_i : (!ce_n_i && !oe_n_i) ?
                  (mode_q == 3'h0 ? mem_q : sr_q ? 16'h00A0 : {8'h00, st}) : ~last_q;
   // Open-drain busy line resolved against its pull-up.
   assign ready_busy_n_o = mode_q == 3'h0 || mode_q == 3'h6;
   // Sector erase writes leave modes 4 and 5 as they are.
   always @(posedge clk_i) begin
      we_q <= we_n_i;
      oe_q <= oe_n_i;
      if (dq_oe_i || (!ce_n_i && !oe_n_i)) last_q <= bus_o;
      if (oe_n_i && !oe_q && mode_q != 3'h0 && mode_q != 3'h6) tog_q <= ~tog_q;
      if (we_n_i && !we_q && mode_q == 3'h3 && dq_i == 16'h0070) sr_q <= 1'b1;
      else if (oe_n_i && !oe_q) sr_q <= 1'b0;
      if (load_i) mode_q <= mode_i;
      else if (we_n_i && !we_q && mode_q == 3'h0) mem_q <= dq_i;
      else if (we_n_i && !we_q && (mode_q == 3'h3 || mode_q == 3'h2) &&
               (dq_i == 16'h00F0 || (dq_i == 16'h0071 && addr_i == 22'h00_0555)))
         mode_q <= 3'h0;
   end
endmodule

// ==== tb/tb.sv ====
// Self-checking bench for the flash status host controller.
`timescale 1ns/1ps
module tb;
   logic        clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, we = 1'b0, load = 1'b0;
   logic        ack, dq_oe, ce_n, oe_n, we_n, rbn;
   logic [7:0]  adr = 8'h00;
   logic [2:0]  mode = 3'h0;
   logic [15:0] bus, dq_o;
   logic [21:0] fa;
   logic [31:0] wd = 32'h0000_0000, dat, rd, e, m, r, exp_q[$], msk_q[$];
   int          bad_count = 0, total_checks = 0, seed = 78;
   // Free-running 100 MHz clock.
   initial forever #5 clk_i = ~clk_i;
   flash_host_ctrl u_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(cyc),
      .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wd), .wb_ack_o(ack),
      .wb_dat_o(dat), .dq_i(bus), .dq_o(dq_o), .dq_oe_o(dq_oe), .flash_addr_o(fa),
      .ce_n_o(ce_n), .oe_n_o(oe_n), .we_n_o(we_n), .ready_busy_n_i(rbn));
   flash_dev_model u_dev (.clk_i(clk_i), .load_i(load), .mode_i(mode), .ce_n_i(ce_n),
      .oe_n_i(oe_n), .we_n_i(we_n), .addr_i(fa), .dq_i(dq_o), .dq_oe_i(dq_oe), .bus_o(bus),
      .ready_busy_n_o(rbn));
   // Each read answer takes the oldest note off the queue.
   always @(posedge clk_i) if (ack === 1'b1 && we === 1'b0 && exp_q.size() > 0) begin
      e = exp_q.pop_front();
      m = msk_q.pop_front();
      if (m != 0) total_checks++;
      if ((dat & m) !== (e & m)) begin
         bad_count++;
         $display("BAD t=%0t exp=%h got=%h", $time, e & m, dat & m);
      end
   end
   // One classic cycle; the request is held until ack is seen at an edge.
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, x, k);
      int n;
      n = 0;
      cyc <= 1'b1;
      we <= w;
      adr <= a;
      wd <= d;
      if (!w) exp_q.push_back(x);
      if (!w) msk_q.push_back(k);
      do @(posedge clk_i); while (ack !== 1'b1 && ++n < 64);
      if (ack !== 1'b1) begin
         bad_count++;
         $display("BAD t=%0t ack wait exp=%h got=%h", $time, 1'b1, ack);
      end
      rd = dat;
      cyc <= 1'b0;
      @(posedge clk_i);
   endtask
   // Sets the device mode (7 keeps it), runs one op and checks status once idle.
   task automatic run(input logic [2:0] md, op, input logic [31:0] a, x, k);
      int n;
      mode <= md;
      load <= md != 3'h7;
      @(posedge clk_i);
      load <= 1'b0;
      wb(1'b1, 8'h0C, 32'h0000_005E, 0, 0);
      wb(1'b1, 8'h04, a, 0, 0);
      wb(1'b1, 8'h00, {29'h0, op}, 0, 0);
      n = 0;
      do wb(1'b0, 8'h0C, 0, 0, 0); while (rd[0] !== 1'b0 && ++n < 400);
      if (rd[0] !== 1'b0) begin
         bad_count++;
         $display("BAD t=%0t busy wait exp=%h got=%h", $time, 1'b0, rd[0]);
      end
      wb(1'b0, 8'h0C, 0, x, k);
      $display("test op %0d mode %0d done", op, md);
   endtask
   task automatic final_report();
      $display("checks %0d bad %0d", total_checks, bad_count);
      if (bad_count == 0 && total_checks > 0 && exp_q.size() == 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   // Watchdog against a hung handshake.
   initial begin
      #500000;
      bad_count++;
      final_report();
   end
   // Main sequence: reset, register checks, then each device state in turn.
   initial begin
      repeat (4) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      wb(1'b0, 8'h10, 0, 0, 32'hFFFF_FFFF);
      wb(1'b0, 8'h24, 0, 0, 32'hFFFF_FFFF);
      repeat (2) begin
         r = $random(seed);
         wb(1'b1, 8'h08, r, 0, 0);
         run(3'h0, flash_host_pkg::OP_WRITE, r >> 10, 32'h20, 32'h21);
         run(3'h7, flash_host_pkg::OP_READ, r >> 10, 32'h20, 32'h21);
         wb(1'b0, 8'h10, 0, r & 32'h0000_FFFF, 32'h0000_FFFF);
      end
      run(3'h0, flash_host_pkg::OP_POLL, 0, 32'h22, 32'h3F);
      run(3'h1, flash_host_pkg::OP_READ, 0, 0, 32'h21);
      wb(1'b0, 8'h10, 0, 32'h80, 32'hBF);
      run(3'h2, flash_host_pkg::OP_POLL, 0, 32'h0A, 32'h3F);
      run(3'h7, flash_host_pkg::OP_ABORT_RESET, 0, 32'h22, 32'h23);
      run(3'h3, flash_host_pkg::OP_POLL, 0, 32'h06, 32'h3F);
      run(3'h7, flash_host_pkg::OP_READ, 0, 0, 32'h21);
      wb(1'b0, 8'h10, 0, 32'h28, 32'hAB);
      wb(1'b1, 8'h08, 32'h0000_0070, 0, 0);
      run(3'h7, flash_host_pkg::OP_WRITE, 32'h555, 0, 32'h21);
      run(3'h7, flash_host_pkg::OP_READ, 0, 0, 32'h21);
      wb(1'b0, 8'h10, 0, 32'hA0, 32'hBE);
      run(3'h7, flash_host_pkg::OP_CLR_SR, 0, 32'h20, 32'h21);
      run(3'h3, flash_host_pkg::OP_CLR_RESET, 0, 32'h20, 32'h21);
      run(3'h4, flash_host_pkg::OP_ERASE_ADD, 0, 0, 32'h11);
      run(3'h5, flash_host_pkg::OP_ERASE_ADD, 0, 32'h10, 32'h11);
      run(3'h6, flash_host_pkg::OP_POLL, 0, 32'h22, 32'h3F);
      wb(1'b0, 8'h10, 0, 32'h80, 32'h80);
      wb(1'b1, 8'h00, 32'h0000_0007, 0, 0);
      wb(1'b0, 8'h0C, 0, 32'h40, 32'h40);
      final_report();
   end
endmodule
